// ===== src/mrr_ctrl.sv
// controller end: issues register reads, spaces them, polls temperature
`timescale 1ns/100ps
module mrr_ctrl #(
	parameter int POLL_CYCLES = mrr_pkg::POLL_CK
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// link to the device
	mrr_if.ctl link,
	// user read request
	input wire logic req_valid,
	input wire logic [7:0] req_addr,
	output logic req_ready,
	// user read answer
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_err,
	// neighbouring scheduler
	input wire logic rd_issue,
	input wire logic wr_issue,
	input wire logic [4:0] bl_eff,
	input wire logic banks_idle,
	output logic wr_allowed,
	output logic mrw_allowed,
	// temperature
	output logic [2:0] temp_status,
	output logic temp_hot
);
	typedef enum logic [2:0]
	{
		H_IDLE = 3'b000,
		H_CMD = 3'b001,
		H_NOP = 3'b010,
		H_WAIT = 3'b011,
		H_CAP1 = 3'b100
	} mrr_hstate_t;

	mrr_hstate_t state_ff;
	mrr_hstate_t nxt_state;
	logic [3:0] cnt_ff;
	logic [7:0] addr_ff;
	logic poll_own_ff;
	logic poll_pend_ff;
	logic [31:0] poll_cnt_ff;
	logic [7:0] gap_ff;
	logic [7:0] wr_blk_ff;
	logic [7:0] mrw_blk_ff;
	logic [7:0] byte0_ff;
	logic [1:0] cal01_ff;
	logic rsp_valid_ff;
	logic rsp_err_ff;
	logic [7:0] rsp_data_ff;
	logic [2:0] temp_ff;
	logic cs_n_ff;
	logic [9:0] ca_r_ff;
	logic [9:0] ca_f_ff;
	logic refuse;
	logic start;
	logic slot_free;
	logic [7:0] rd_gap;
	logic [7:0] wr_gap;
	logic [7:0] result;

	// cal patterns only with all banks idle
	assign refuse = (mrr_pkg::cal_kind(req_addr) != mrr_pkg::MRR_CAL_NONE) && !banks_idle;
	// a READ or WRITE on the pins now has not loaded the gap yet
	assign slot_free = (state_ff == H_IDLE) && (gap_ff == 8'h0) && !wr_issue && !rd_issue;
	assign req_ready = slot_free && !poll_pend_ff;
	assign start = slot_free && (poll_pend_ff || (req_valid && !refuse));
	assign rd_gap = 8'(bl_eff / 5'h2) - 8'h1;
	assign wr_gap = 8'(mrr_pkg::WL + 1 + mrr_pkg::WTR_CK - 1) + 8'(bl_eff / 5'h2);

	// one read in flight, never cut short
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			H_IDLE:
			begin
				if (start)
					nxt_state = H_CMD;
			end
			H_CMD:
			begin
				nxt_state = H_NOP;
			end
			H_NOP:
			begin
				if (cnt_ff <= 4'(mrr_pkg::RL - mrr_pkg::TMRR + 2))
					nxt_state = H_WAIT;
			end
			H_WAIT:
			begin
				if (cnt_ff == 4'h0)
					nxt_state = H_CAP1;
			end
			H_CAP1:
			begin
				nxt_state = H_IDLE;
			end
			default:
			begin
				nxt_state = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			state_ff <= H_IDLE;
		else
			state_ff <= nxt_state;
	end

	// MRR for one cycle, then NOP
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cs_n_ff <= 1'b1;
			ca_r_ff <= 10'h000;
			ca_f_ff <= 10'h000;
		end
		else if (nxt_state == H_CMD)
		begin
			cs_n_ff <= 1'b0;
			ca_r_ff <= {(poll_pend_ff ? mrr_pkg::TEMPERATURE_STATUS_ADDR[7:2] : req_addr[7:2]), mrr_pkg::CA_MRR};
			ca_f_ff <= {8'h00, (poll_pend_ff ? mrr_pkg::TEMPERATURE_STATUS_ADDR[1:0] : req_addr[1:0])};
		end
		else if (nxt_state == H_NOP)
		begin
			cs_n_ff <= 1'b0;
			ca_r_ff <= {7'h00, mrr_pkg::CA_NOP};
			ca_f_ff <= 10'h000;
		end
		else
		begin
			cs_n_ff <= 1'b1;
			ca_r_ff <= 10'h000;
			ca_f_ff <= 10'h000;
		end
	end

	// latency count and request capture
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_ff <= 4'h0;
			addr_ff <= 8'h00;
			poll_own_ff <= 1'b0;
		end
		else if (start)
		begin
			addr_ff <= poll_pend_ff ? mrr_pkg::TEMPERATURE_STATUS_ADDR : req_addr;
			poll_own_ff <= poll_pend_ff;
		end
		else if (state_ff == H_CMD)
			cnt_ff <= 4'(mrr_pkg::RL);
		else if (cnt_ff != 4'h0)
			cnt_ff <= cnt_ff - 4'h1;
	end

	// poll timer; a new expiry wins over the clear
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			poll_cnt_ff <= 32'(POLL_CYCLES - 1);
			poll_pend_ff <= 1'b0;
		end
		else
		begin
			poll_cnt_ff <= (poll_cnt_ff == 32'h0) ? 32'(POLL_CYCLES - 1) : poll_cnt_ff - 32'h1;
			if (poll_cnt_ff == 32'h0)
				poll_pend_ff <= 1'b1;
			else if (start && poll_pend_ff)
				poll_pend_ff <= 1'b0;
		end
	end

	// gap to the next MRR; may be one cycle conservative
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			gap_ff <= 8'h0;
		else if (wr_issue && wr_gap > gap_ff)
			gap_ff <= wr_gap;
		else if (rd_issue && rd_gap > gap_ff)
			gap_ff <= rd_gap;
		else if (gap_ff != 8'h0)
			gap_ff <= gap_ff - 8'h1;
	end

	// MRR to WRITE or MRW spacing
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_blk_ff <= 8'h0;
			mrw_blk_ff <= 8'h0;
		end
		else if (state_ff == H_CMD)
		begin
			wr_blk_ff <= 8'(mrr_pkg::MRR_TO_WR - 1);
			mrw_blk_ff <= 8'(mrr_pkg::MRR_TO_MRW - 1);
		end
		else
		begin
			wr_blk_ff <= (wr_blk_ff != 8'h0) ? wr_blk_ff - 8'h1 : 8'h0;
			mrw_blk_ff <= (mrw_blk_ff != 8'h0) ? mrw_blk_ff - 8'h1 : 8'h0;
		end
	end

	// cal reads fold their four bit-0 samples into one byte, first beat high
	assign result = (mrr_pkg::cal_kind(addr_ff) != mrr_pkg::MRR_CAL_NONE) ?
		{4'h0, cal01_ff, link.dq_r[0], link.dq_f[0]} : byte0_ff;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			byte0_ff <= 8'h00;
			cal01_ff <= 2'h0;
			rsp_valid_ff <= 1'b0;
			rsp_err_ff <= 1'b0;
			rsp_data_ff <= 8'h00;
			temp_ff <= mrr_pkg::TEMP_RESET;
		end
		else
		begin
			rsp_valid_ff <= (state_ff == H_CAP1) && !poll_own_ff;
			rsp_err_ff <= req_valid && req_ready && refuse;
			if (state_ff == H_WAIT && cnt_ff == 4'h0)
			begin
				byte0_ff <= link.dq_r[7:0];
				cal01_ff <= {link.dq_r[0], link.dq_f[0]};
			end
			if (state_ff == H_CAP1 && !poll_own_ff)
				rsp_data_ff <= result;
			if (state_ff == H_CAP1 && poll_own_ff)
				temp_ff <= result[2:0];
		end
	end

	assign link.cs_n = cs_n_ff;
	assign link.ca_r = ca_r_ff;
	assign link.ca_f = ca_f_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_err = rsp_err_ff;
	assign rsp_data = rsp_data_ff;
	assign wr_allowed = (wr_blk_ff == 8'h0) && (state_ff != H_CMD);
	assign mrw_allowed = (mrw_blk_ff == 8'h0) && (state_ff != H_CMD);
	assign temp_status = temp_ff;
	assign temp_hot = (temp_ff == mrr_pkg::TEMP_HOT);
endmodule

// ===== include/mrr_pkg.sv
// shared constants for the mode register read path
package mrr_pkg;
	// latencies in clock cycles
	localparam int RL = 3;
	localparam int WL = 1;
	localparam int TMRR = 2;
	localparam int MRR_BL = 4;
	// timing in picoseconds, converted to cycles
	localparam int TCK_PS = 4000;
	localparam int TDQSCK_MAX_PS = 5500;
	localparam int TWTR_PS = 7500;
	localparam int DQSCK_CK = (TDQSCK_MAX_PS + TCK_PS - 1) / TCK_PS;
	localparam int WTR_CK = (TWTR_PS + TCK_PS - 1) / TCK_PS;
	localparam int MRR_TO_WR = RL + DQSCK_CK + MRR_BL / 2 + 1 - WL;
	localparam int MRR_TO_MRW = RL + DQSCK_CK + MRR_BL / 2 + 1;
	// sensor update interval and host polling
	localparam int CLK_KHZ = 250000;
	localparam int TSI_MS = 16;
	localparam int TSI_CK = TSI_MS * CLK_KHZ;
	localparam int TSI_FIRST = 3;
	// 10 C/s slope, 1 ms response, 2 C headroom allow up to 183 ms
	localparam int POLL_MS = 150;
	localparam int POLL_CK = POLL_MS * CLK_KHZ;
	// register addresses
	localparam logic [7:0] TEMPERATURE_STATUS_ADDR = 8'h04;
	localparam logic [7:0] CAL_PATTERN_A_ADDR = 8'h20;
	localparam logic [7:0] CAL_PATTERN_B_ADDR = 8'h28;
	// beat 0 in the top bit
	localparam logic [3:0] CAL_PATTERN_A = 4'hA;
	localparam logic [3:0] CAL_PATTERN_B = 4'h3;
	localparam logic [2:0] TEMP_HOT = 3'h3;
	localparam logic [2:0] TEMP_RESET = 3'h0;
	// command encodings on ca[3:0] at the rising edge
	localparam logic [3:0] CA_MRR = 4'h8;
	localparam logic [2:0] CA_NOP = 3'h7;
	localparam int DQ_W = 32;
	localparam int LANES = DQ_W / 8;
	// calibration kind of an address
	typedef enum logic [1:0]
	{
		MRR_CAL_NONE = 2'b00,
		MRR_CAL_A = 2'b01,
		MRR_CAL_B = 2'b10
	} mrr_cal_t;
	function automatic mrr_cal_t cal_kind(input logic [7:0] addr);
		if (addr == CAL_PATTERN_A_ADDR)
			return MRR_CAL_A;
		else if (addr == CAL_PATTERN_B_ADDR)
			return MRR_CAL_B;
		else
			return MRR_CAL_NONE;
	endfunction
endpackage

// ===== include/mrr_if.sv
// command/address and read data link between controller and device
`timescale 1ns/100ps
interface mrr_if;
	logic cs_n;
	logic [9:0] ca_r;
	logic [9:0] ca_f;
	logic [mrr_pkg::DQ_W-1:0] dq_r;
	logic [mrr_pkg::DQ_W-1:0] dq_f;
	logic dq_oe;
	logic [mrr_pkg::LANES-1:0] dqs_r;
	logic [mrr_pkg::LANES-1:0] dqs_f;
	logic dqs_oe;
	modport dev (input cs_n, ca_r, ca_f, output dq_r, dq_f, dq_oe, dqs_r, dqs_f, dqs_oe);
	modport ctl (output cs_n, ca_r, ca_f, input dq_r, dq_f, dq_oe, dqs_r, dqs_f, dqs_oe);
endinterface

// ===== src/mrr_device.sv
// device end: mode register read decode, burst return and temperature status
`timescale 1ns/100ps
// Behaviour
// - MRR: cs low, CA0-2 low, CA3 high
// - address from fall CA1:0, rise CA9:4
// - register byte on DQ7:0, first beat
// - later beats defined, cal reads pattern
// - upper lanes defined, except calibration lanes
// - all strobes toggle, burst of four
// - two cycle command period, NOP only
// - controller never interrupts a register read
// - controller spaces register read to WRITE
// - controller spaces register read to MRW
// - READ to register read, BL/2 cycles
// - WRITE to register read spacing
// - truncated bursts use effective length
// - temperature readable via register read
// - temperature refreshed at most every 16 ms
// - fresh temperature on low power exit; updated only if the two samples agree in the exit cycle
// - field bits 2:0, 011b may exceed 85C
// - controller polls temperature often enough
// - cal pattern on bit 0 per lane
// - other lane bits copy bit 0
// - cal reads only while idle
// - patterns 1010 and 0011 over beats
// - bank state unchanged by register read
module mrr_device #(
	parameter int TSI_CYCLES = mrr_pkg::TSI_CK
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// link to the controller
	mrr_if.dev link,
	// sensor code from the analog block
	input wire logic [2:0] temp_code,
	// pulse when leaving self refresh or power-down
	input wire logic lp_exit,
	// status
	output logic mrr_busy,
	output logic cmd_violation
);
	typedef enum logic [1:0]
	{
		D_IDLE = 2'b00,
		D_LAT = 2'b01,
		D_B0 = 2'b10,
		D_B1 = 2'b11
	} mrr_dstate_t;

	mrr_dstate_t state_ff;
	mrr_dstate_t nxt_state;
	logic [2:0] lat_cnt_ff;
	logic [7:0] addr_ff;
	logic [2:0] temp_s1_ff;
	logic [2:0] temp_s2_ff;
	logic [2:0] temp_s3_ff;
	logic [2:0] temp_status_ff;
	logic [31:0] tsi_cnt_ff;
	logic cmd_violation_ff;
	logic [mrr_pkg::DQ_W-1:0] dq_r_ff;
	logic [mrr_pkg::DQ_W-1:0] dq_f_ff;
	logic dq_oe_ff;
	logic [mrr_pkg::LANES-1:0] dqs_r_ff;
	logic [mrr_pkg::LANES-1:0] dqs_f_ff;
	logic dqs_oe_ff;
	logic mrr_cmd;
	logic [7:0] cmd_addr;
	logic in_tmrr;
	logic temp_update;

	assign mrr_cmd = !link.cs_n && (link.ca_r[3:0] == mrr_pkg::CA_MRR);
	assign cmd_addr = {link.ca_r[9:4], link.ca_f[1:0]};

	// register contents returned on the first beat
	function automatic logic [7:0] reg_byte(input logic [7:0] addr, input logic [2:0] temp);
		if (addr == mrr_pkg::TEMPERATURE_STATUS_ADDR)
			return {5'h00, temp};
		else
			return 8'h00;
	endfunction

	// one data word for beat number beat of the burst
	function automatic logic [mrr_pkg::DQ_W-1:0] beat_word(input logic [7:0] addr, input logic [2:0] temp,
		input logic [1:0] beat);
		logic [3:0] pat;
		pat = 4'h0;
		case (mrr_pkg::cal_kind(addr))
			mrr_pkg::MRR_CAL_A:
			begin
				pat = mrr_pkg::CAL_PATTERN_A;
				// bit 0 of every lane, copied to all bits
				return {mrr_pkg::DQ_W{pat[3 - beat]}};
			end
			mrr_pkg::MRR_CAL_B:
			begin
				pat = mrr_pkg::CAL_PATTERN_B;
				return {mrr_pkg::DQ_W{pat[3 - beat]}};
			end
			default:
			begin
				// byte on low lane first beat
				if (beat == 2'h0)
					return {{(mrr_pkg::DQ_W - 8){1'b0}}, reg_byte(addr, temp)};
				else
					return '0;
			end
		endcase
	endfunction

	// second cycle of the command period, the one after the MRR
	// window where only NOP is legal
	assign in_tmrr = (state_ff == D_LAT) && (lat_cnt_ff > 3'(mrr_pkg::RL - mrr_pkg::TMRR));

	// burst sequencing, a second MRR while busy is ignored
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			D_IDLE:
			begin
				if (mrr_cmd)
					nxt_state = D_LAT;
			end
			D_LAT:
			begin
				if (lat_cnt_ff == 3'h0)
					nxt_state = D_B0;
			end
			D_B0:
			begin
				nxt_state = D_B1;
			end
			D_B1:
			begin
				nxt_state = D_IDLE;
			end
			default:
			begin
				nxt_state = D_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			state_ff <= D_IDLE;
		else
			state_ff <= nxt_state;
	end

	// read latency count and address capture
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			lat_cnt_ff <= 3'h0;
			addr_ff <= 8'h00;
		end
		else if (state_ff == D_IDLE && mrr_cmd)
		begin
			lat_cnt_ff <= 3'(mrr_pkg::RL - 1);
			addr_ff <= cmd_addr;
		end
		else if (state_ff == D_LAT && lat_cnt_ff != 3'h0)
		begin
			lat_cnt_ff <= lat_cnt_ff - 3'h1;
		end
	end

	// flag a non-NOP command inside the command period
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			cmd_violation_ff <= 1'b0;
		else
			cmd_violation_ff <= in_tmrr && !link.cs_n && (link.ca_r[2:0] != mrr_pkg::CA_NOP);
	end

	// sensor code arrives from another domain; its bits may skew, so a code is loaded only when two samples agree
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			temp_s1_ff <= mrr_pkg::TEMP_RESET;
			temp_s2_ff <= mrr_pkg::TEMP_RESET;
			temp_s3_ff <= mrr_pkg::TEMP_RESET;
		end
		else
		begin
			temp_s1_ff <= temp_code;
			temp_s2_ff <= temp_s1_ff;
			temp_s3_ff <= temp_s2_ff;
		end
	end

	// periodic refresh, retried while unstable; forced on low power exit only if the samples agree in that cycle
	assign temp_update = ((tsi_cnt_ff == 32'h0) || lp_exit) && (temp_s2_ff == temp_s3_ff);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tsi_cnt_ff <= 32'(mrr_pkg::TSI_FIRST);
			temp_status_ff <= mrr_pkg::TEMP_RESET;
		end
		else if (temp_update)
		begin
			tsi_cnt_ff <= 32'(TSI_CYCLES - 1);
			// three bit field, 011b means hot
			temp_status_ff <= temp_s2_ff;
		end
		else if (tsi_cnt_ff != 32'h0)
			tsi_cnt_ff <= tsi_cnt_ff - 32'h1;
	end

	// burst drive, strobes toggle on every beat of the burst
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dq_r_ff <= '0;
			dq_f_ff <= '0;
			dq_oe_ff <= 1'b0;
			dqs_r_ff <= '0;
			dqs_f_ff <= '0;
			dqs_oe_ff <= 1'b0;
		end
		else if (nxt_state == D_B0)
		begin
			dq_r_ff <= beat_word(addr_ff, temp_status_ff, 2'h0);
			dq_f_ff <= beat_word(addr_ff, temp_status_ff, 2'h1);
			dq_oe_ff <= 1'b1;
			dqs_r_ff <= '1;
			dqs_f_ff <= '0;
			dqs_oe_ff <= 1'b1;
		end
		else if (nxt_state == D_B1)
		begin
			dq_r_ff <= beat_word(addr_ff, temp_status_ff, 2'h2);
			dq_f_ff <= beat_word(addr_ff, temp_status_ff, 2'h3);
			dq_oe_ff <= 1'b1;
			dqs_r_ff <= '1;
			dqs_f_ff <= '0;
			dqs_oe_ff <= 1'b1;
		end
		else
		begin
			// bus released; drive zeros so nothing floats in simulation
			dq_r_ff <= '0;
			dq_f_ff <= '0;
			dq_oe_ff <= 1'b0;
			dqs_r_ff <= '0;
			dqs_f_ff <= '0;
			dqs_oe_ff <= 1'b0;
		end
	end

	assign link.dq_r = dq_r_ff;
	assign link.dq_f = dq_f_ff;
	assign link.dq_oe = dq_oe_ff;
	assign link.dqs_r = dqs_r_ff;
	assign link.dqs_f = dqs_f_ff;
	assign link.dqs_oe = dqs_oe_ff;
	assign mrr_busy = (state_ff != D_IDLE);
	assign cmd_violation = cmd_violation_ff;
endmodule

// ===== dv/mrr_link_assertions.sv
// concurrent checks on the controller-device read link
`timescale 1ns/100ps
module mrr_link_assertions (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// link signals
	input wire logic cs_n,
	input wire logic [9:0] ca_r,
	input wire logic [9:0] ca_f,
	input wire logic [mrr_pkg::DQ_W-1:0] dq_r,
	input wire logic [mrr_pkg::DQ_W-1:0] dq_f,
	input wire logic dq_oe,
	input wire logic [mrr_pkg::LANES-1:0] dqs_r,
	input wire logic [mrr_pkg::LANES-1:0] dqs_f,
	input wire logic dqs_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic is_mrr;
	logic is_nop;
	logic [7:0] addr;
	logic [7:0] addr_ff;
	assign is_mrr = !cs_n && ca_r[3:0] == mrr_pkg::CA_MRR;
	assign is_nop = !cs_n && ca_r[2:0] == mrr_pkg::CA_NOP;
	assign addr = {ca_r[9:4], ca_f[1:0]};
	// address of the read in flight; spacing keeps it valid for the burst
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			addr_ff <= 8'h00;
		else if (is_mrr)
			addr_ff <= addr;
	read_latency_a: assert property (
		is_mrr |-> ##1 !dq_oe [*3] ##1 dq_oe [*2] ##1 !dq_oe)
		else $error("read data not on its cycle");
	strobe_toggle_a: assert property (
		dq_oe |-> dqs_oe && &dqs_r && !(|dqs_f))
		else $error("strobes not toggling in burst");
	burst_four_a: assert property (
		$rose(dq_oe) |=> dq_oe ##1 !dq_oe)
		else $error("burst not four beats");
	burst_origin_a: assert property (
		$rose(dq_oe) |-> $past(is_mrr, 4))
		else $error("burst without a read command");
	nop_period_a: assert property (
		is_mrr |=> is_nop ##1 cs_n)
		else $error("command period not nop only");
	read_spacing_a: assert property (
		is_mrr |=> !is_mrr [*4])
		else $error("read interrupted by another read");
	pattern_a_a: assert property (
		$rose(dq_oe) && addr_ff == mrr_pkg::CAL_PATTERN_A_ADDR |-> (&dq_r && !(|dq_f)) [*2])
		else $error("pattern a wrong");
	pattern_b_a: assert property (
		$rose(dq_oe) && addr_ff == mrr_pkg::CAL_PATTERN_B_ADDR |-> !(|dq_r) && !(|dq_f) ##1 &dq_r && &dq_f)
		else $error("pattern b wrong");
	upper_defined_a: assert property (
		dq_oe && addr_ff != mrr_pkg::CAL_PATTERN_A_ADDR && addr_ff != mrr_pkg::CAL_PATTERN_B_ADDR
		|-> !(|dq_r[mrr_pkg::DQ_W-1:8]) && !(|dq_f))
		else $error("undefined beats not at chosen level");
	cover property (is_mrr && addr == mrr_pkg::TEMPERATURE_STATUS_ADDR);
	cover property (is_mrr && addr == mrr_pkg::CAL_PATTERN_A_ADDR);
	cover property (is_mrr && addr == mrr_pkg::CAL_PATTERN_B_ADDR);
endmodule

// ===== dv/mode_register_read_path_tb_top.sv
// testbench: controller and device joined, user reads and command spacing
`timescale 1ns/100ps
module mode_register_read_path_tb_top;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic req_valid = 1'b0;
	logic [7:0] req_addr = 8'h00;
	logic rd_issue = 1'b0;
	logic wr_issue = 1'b0;
	logic [4:0] bl_eff = 5'h04;
	logic banks_idle = 1'b1;
	logic [2:0] temp_code = 3'h3;
	logic lp_exit = 1'b0;
	logic req_ready, rsp_valid, rsp_err, wr_allowed, mrw_allowed, temp_hot, busy, viol, busy_b, viol_b;
	logic [7:0] rsp_data;
	logic [2:0] temp_status;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	int flags = 0;
	mrr_if link();
	mrr_if link_b();
	mrr_device #(.TSI_CYCLES(50)) i_mrr_device (.core_clk(core_clk), .rstn(rstn), .link(link),
		.temp_code(temp_code), .lp_exit(lp_exit), .mrr_busy(busy), .cmd_violation(viol));
	// second device faces the bench, which breaks the command period on purpose
	mrr_device #(.TSI_CYCLES(50)) i_mrr_device_b (.core_clk(core_clk), .rstn(rstn), .link(link_b),
		.temp_code(temp_code), .lp_exit(1'b0), .mrr_busy(busy_b), .cmd_violation(viol_b));
	mrr_ctrl #(.POLL_CYCLES(200)) i_mrr_ctrl (.core_clk(core_clk), .rstn(rstn), .link(link),
		.req_valid(req_valid), .req_addr(req_addr), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_err(rsp_err), .rd_issue(rd_issue), .wr_issue(wr_issue), .bl_eff(bl_eff),
		.banks_idle(banks_idle), .wr_allowed(wr_allowed), .mrw_allowed(mrw_allowed),
		.temp_status(temp_status), .temp_hot(temp_hot));
	mrr_link_assertions i_mrr_link_assertions (.core_clk(core_clk), .rstn(rstn), .cs_n(link.cs_n),
		.ca_r(link.ca_r), .ca_f(link.ca_f), .dq_r(link.dq_r), .dq_f(link.dq_f), .dq_oe(link.dq_oe),
		.dqs_r(link.dqs_r), .dqs_f(link.dqs_f), .dqs_oe(link.dqs_oe));
	always #2 core_clk = ~core_clk;
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (viol === 1'b1)
			flags <= flags + 1;
		if (cycles == 3000)
		begin
			mismatches++;
			$display("mismatch timeout expected 0 seen %0d", cycles);
			stop_test();
		end
	end
	// one user read: answer, its latency, pins used and blocked windows
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic err, input logic idle);
		int wl, ml, vn, ec, pins, bz;
		wl = 0;
		ml = 0;
		vn = 0;
		ec = 0;
		pins = 0;
		bz = 0;
		@(posedge core_clk);
		banks_idle <= idle;
		req_addr <= addr;
		req_valid <= 1'b1;
		do @(negedge core_clk); while (req_ready !== 1'b1);
		@(posedge core_clk);
		req_valid <= 1'b0;
		for (int n = 1; n <= 12; n++)
		begin
			@(negedge core_clk);
			wl += (wr_allowed === 1'b0);
			ml += (mrw_allowed === 1'b0);
			ec += (rsp_err === 1'b1);
			bz += (busy === 1'b1);
			if (n <= 7 && link.cs_n === 1'b0)
				pins++;
			if (rsp_valid === 1'b1 && vn == 0)
				vn = n;
		end
		chk("error", err, ec);
		chk("pins low", err ? 0 : mrr_pkg::TMRR, pins);
		chk("busy", err ? 0 : mrr_pkg::RL + mrr_pkg::MRR_BL / 2, bz);
		if (!err)
		begin
			chk("latency", 7, vn);
			chk("data", exp, rsp_data);
			// write allowed again one write latency before register write
			chk("block diff", mrr_pkg::WL, ml - wl);
			chk("block length", 1, wl >= mrr_pkg::MRR_TO_WR);
		end
	endtask
	// pulse a scheduler command with a read waiting, measure cycles to the read
	task automatic gap(input logic wr, input logic [4:0] bl, input int lo);
		int n;
		n = 0;
		@(posedge core_clk);
		wr_issue <= wr;
		rd_issue <= !wr;
		bl_eff <= bl;
		req_addr <= 8'h05;
		req_valid <= 1'b1;
		@(posedge core_clk);
		wr_issue <= 1'b0;
		rd_issue <= 1'b0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (!(link.cs_n === 1'b0 && link.ca_r[3:0] === mrr_pkg::CA_MRR) && n < 40);
		@(posedge core_clk);
		req_valid <= 1'b0;
		chk("gap low", 1, n >= lo);
		chk("gap high", 1, n <= lo + 4);
		repeat (12) @(posedge core_clk);
	endtask
	// non-nop inside the command period of the second device
	task automatic bad_cmd();
		int hits, bb;
		hits = 0;
		bb = 0;
		@(posedge core_clk);
		link_b.cs_n <= 1'b0;
		link_b.ca_r <= 10'h018;
		@(posedge core_clk);
		link_b.ca_r <= 10'h000;
		@(posedge core_clk);
		link_b.cs_n <= 1'b1;
		repeat (5)
		begin
			@(negedge core_clk);
			hits += (viol_b === 1'b1);
			bb += (busy_b === 1'b1);
		end
		chk("violation", 1, hits);
		chk("busy b", mrr_pkg::RL + mrr_pkg::MRR_BL / 2 - 1, bb);
	endtask
	initial
	begin
		link_b.cs_n = 1'b1;
		link_b.ca_r = 10'h000;
		link_b.ca_f = 10'h000;
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		@(negedge core_clk);
		chk("reset outputs", 8'h70, {req_ready, wr_allowed, mrw_allowed, temp_status, link.dq_oe});
		rd(mrr_pkg::TEMPERATURE_STATUS_ADDR, 8'h03, 1'b0, 1'b1);
		repeat (250) @(posedge core_clk);
		chk("temperature", 4'h7, {temp_status, temp_hot});
		temp_code <= 3'h1;
		repeat (4) @(posedge core_clk);
		lp_exit <= 1'b1;
		@(posedge core_clk);
		lp_exit <= 1'b0;
		rd(mrr_pkg::TEMPERATURE_STATUS_ADDR, 8'h01, 1'b0, 1'b1);
		rd(mrr_pkg::CAL_PATTERN_A_ADDR, 8'h0A, 1'b0, 1'b1);
		rd(mrr_pkg::CAL_PATTERN_B_ADDR, 8'h03, 1'b0, 1'b1);
		rd(8'h05, 8'h00, 1'b0, 1'b1);
		rd(mrr_pkg::CAL_PATTERN_A_ADDR, 8'h00, 1'b1, 1'b0);
		rd(mrr_pkg::TEMPERATURE_STATUS_ADDR, 8'h01, 1'b0, 1'b0);
		gap(1'b1, 5'h04, mrr_pkg::WL + 1 + 2 + mrr_pkg::WTR_CK);
		gap(1'b0, 5'h08, 4);
		gap(1'b1, 5'h02, mrr_pkg::WL + 1 + 1 + mrr_pkg::WTR_CK);
		gap(1'b0, 5'h10, 8);
		bad_cmd();
		chk("main violations", 0, flags);
		stop_test();
	end
endmodule
